// File: hdl/chunk_mem.sv
// Purpose: Word store for the cache chunk data registers
// Assumes: One write port with byte enables, one registered read port
// Notes: Read data is valid the cycle after the address is presented
module chunk_mem #(
    parameter int DATA_W = msr_bank_pkg::DATA_W,
    parameter int DEPTH = msr_bank_pkg::CHUNK_WORDS,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [DATA_W/8-1:0] wrSel,
    input wire logic [AW-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem [DEPTH];

    // No reset on the array: contents are undefined until software writes them
    always_ff @(posedge clk) begin
        if (wrEn) begin
            for (int b = 0; b < DATA_W / 8; b++) begin
                if (wrSel[b]) begin
                    mem[wrAddr][b*8 +: 8] <= wrData[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        rdData <= mem[rdAddr];
    end
endmodule // chunk_mem

// File: hdl/poweron_config_and_test_regs.sv
// Purpose: Power-on configuration, test control, cache chunk and counter register bank
// Assumes: Classic Wishbone slave, 32-bit data, straps on pins sampled after reset
// Notes: 64-bit registers are split; high words sit at HALF_OFFSET above the low words
// Behaviour
// - Bit 12 of the power-on register reads the strapped bus-init observation enable.
// - Bit 13 reads the strapped queue depth, 1 for one entry and 0 for eight.
// - Bit 14 reads the strapped reset vector, 1 below 1 MByte, 0 below 4 GBytes.
// - Bit 15 reads whether redundancy checking mode is strapped on.
// - Bits 17:16, 21:20 and 25:22 read cluster id, arbitration id and clock ratio.
// - Bits 19:18 read the strapped bus frequency code, 00 66, 10 100, 01 133, 11 reserved.
// - Bit 26 is a software read-write low power mode enable.
// - Power-on bits 63:28 and test control bits 29:0 are reserved and read zero.
// - Test control bit 30 disables the streaming buffer, bit 31 stops split-lock assertion.
// - Chunk data registers 0 to 2 are 64-bit read-write stores at consecutive indices.
// - Index 8B is one 64-bit store used as update signature or chunk 3 data.
// - The power-on register reads the straps captured after reset and its writable bit drives a feature.
//
// Local design decision: the Wishbone interface to the registers.
module poweron_config_and_test_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [msr_bank_pkg::ADDR_W-1:0] adr_i,
    input wire logic [msr_bank_pkg::DATA_W-1:0] dat_i,
    output logic [msr_bank_pkg::DATA_W-1:0] dat_o,
    input wire logic we_i,
    input wire logic [msr_bank_pkg::SEL_W-1:0] sel_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    output logic ack_o,
    input wire logic strapBusInitObserve,
    input wire logic strapQueueDepthOne,
    input wire logic strapLowVector,
    input wire logic strapRedundancyCheck,
    input wire logic [1:0] strapClusterId,
    input wire logic [1:0] strapBusFreq,
    input wire logic [1:0] strapArbId,
    input wire logic [3:0] strapClockRatio,
    input wire logic strapRatioExt,
    input wire logic countEvent0,
    input wire logic countEvent1,
    output logic lowPowerEnable,
    output logic streamBufferDisable,
    output logic splitLockDisable,
    output logic updateTriggerPulse,
    output logic configValid
);
    import msr_bank_pkg::*;

    logic rstMeta_reg;
    logic rstSync_reg;
    bus_state_t state_reg;
    bus_state_t state_next;
    logic [STRAP_W-1:0] strapPins;
    logic [STRAP_W-1:0] strapVal;
    logic captureDone;
    logic lowPower_reg;
    logic [1:0] testCtl_reg;
    logic [63:0] updateTrig_reg;
    logic [63:0] evCount_reg [2];
    logic [DATA_W-1:0] datNext;
    logic [DATA_W-1:0] chunkRd;
    logic [2:0] chunkAddr;
    logic isHigh;
    logic [IDX_W-1:0] regIdx;
    reg_sel_t regSel;
    logic wrCommit;
    logic [31:0] poweronLow;

    function automatic reg_sel_t decodeIdx(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_POWERON: decodeIdx = SEL_POWERON;
            IDX_TEST_CONTROL: decodeIdx = SEL_TEST_CONTROL;
            IDX_UPDATE_TRIG: decodeIdx = SEL_UPDATE_TRIG;
            IDX_CHUNK0, IDX_CHUNK1, IDX_CHUNK2, IDX_CHUNK3: decodeIdx = SEL_CHUNK;
            IDX_EVCNT0, IDX_EVCNT1: decodeIdx = SEL_EVCNT;
            default: decodeIdx = SEL_NONE;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] byteMerge(
        input logic [DATA_W-1:0] oldVal,
        input logic [DATA_W-1:0] newVal,
        input logic [SEL_W-1:0] sel
    );
        byteMerge = oldVal;
        for (int b = 0; b < SEL_W; b++) begin
            if (sel[b]) begin
                byteMerge[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
    endfunction

    // Reset release passes two flops so every flop leaves reset on the same edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    // Strap vector laid out exactly as power-on bits 27:12; bit 26 slot is unused
    assign strapPins = {strapRatioExt, 1'b0, strapClockRatio, strapArbId, strapBusFreq,
                        strapClusterId, strapRedundancyCheck, strapLowVector,
                        strapQueueDepthOne, strapBusInitObserve};

    strap_capture #(
        .WIDTH(STRAP_W)
    ) u_strap (
        .clk(clk),
        .rstSync_n(rstSync_reg),
        .strapPins(strapPins),
        .captured(strapVal),
        .captureDone(captureDone)
    );

    assign configValid = captureDone;

    // Address decode: word index, high-half flag, index within the bank
    assign isHigh = adr_i[HALF_BIT+2];
    assign regIdx = (adr_i[ADDR_W-2:IDX_W+2] == '0) ? adr_i[IDX_W+1:2] : 8'hFF;
    assign regSel = decodeIdx(regIdx);
    assign chunkAddr = {regIdx[1:0], isHigh};
    assign wrCommit = (state_reg == ST_ACCESS) && we_i;

    // Bus handshake: one cycle to read the store, answer on the next
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cyc_i && stb_i && captureDone) begin
                    state_next = ST_ACCESS;
                end
            end
            ST_ACCESS: state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ack_o = (state_reg == ST_DONE);

    // Low word view of the power-on register built from captured straps
    always_comb begin
        poweronLow = WORD_ZERO;
        poweronLow[POC_BUSINIT_OBS_BIT] = strapVal[POC_BUSINIT_OBS_BIT-POC_STRAP_LSB];
        poweronLow[POC_QUEUE_DEPTH_BIT] = strapVal[POC_QUEUE_DEPTH_BIT-POC_STRAP_LSB];
        poweronLow[POC_LOW_VECTOR_BIT] = strapVal[POC_LOW_VECTOR_BIT-POC_STRAP_LSB];
        poweronLow[POC_REDUNDANCY_BIT] = strapVal[POC_REDUNDANCY_BIT-POC_STRAP_LSB];
        poweronLow[POC_CLUSTER_MSB:POC_CLUSTER_LSB] =
            strapVal[POC_CLUSTER_MSB-POC_STRAP_LSB:POC_CLUSTER_LSB-POC_STRAP_LSB];
        poweronLow[POC_BUSFREQ_MSB:POC_BUSFREQ_LSB] =
            strapVal[POC_BUSFREQ_MSB-POC_STRAP_LSB:POC_BUSFREQ_LSB-POC_STRAP_LSB];
        poweronLow[POC_ARBID_MSB:POC_ARBID_LSB] =
            strapVal[POC_ARBID_MSB-POC_STRAP_LSB:POC_ARBID_LSB-POC_STRAP_LSB];
        poweronLow[POC_RATIO_MSB:POC_RATIO_LSB] =
            strapVal[POC_RATIO_MSB-POC_STRAP_LSB:POC_RATIO_LSB-POC_STRAP_LSB];
        poweronLow[POC_RATIO_EXT_BIT] = strapVal[POC_RATIO_EXT_BIT-POC_STRAP_LSB];
        poweronLow[POC_LOWPOWER_BIT] = lowPower_reg;
    end

    // Only the low power bit is writable; strap fields ignore writes
    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            lowPower_reg <= POC_LOWPOWER_RESET;
        end else if (wrCommit && regSel == SEL_POWERON && !isHigh
                     && sel_i[POC_LOWPOWER_BIT/8]) begin
            lowPower_reg <= dat_i[POC_LOWPOWER_BIT];
        end
    end

    assign lowPowerEnable = lowPower_reg;

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            testCtl_reg <= TC_RESET;
        end else if (wrCommit && regSel == SEL_TEST_CONTROL && !isHigh && sel_i[3]) begin
            testCtl_reg <= {dat_i[TC_SPLIT_LOCK_DIS_BIT], dat_i[TC_STREAM_DIS_BIT]};
        end
    end

    assign streamBufferDisable = testCtl_reg[0];
    assign splitLockDisable = testCtl_reg[1];

    // Update trigger keeps its value and flags each write for one cycle
    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            updateTrig_reg <= REG64_RESET;
            updateTriggerPulse <= 1'b0;
        end else begin
            updateTriggerPulse <= wrCommit && regSel == SEL_UPDATE_TRIG;
            if (wrCommit && regSel == SEL_UPDATE_TRIG) begin
                if (isHigh) begin
                    updateTrig_reg[63:32] <= byteMerge(updateTrig_reg[63:32], dat_i, sel_i);
                end else begin
                    updateTrig_reg[31:0] <= byteMerge(updateTrig_reg[31:0], dat_i, sel_i);
                end
            end
        end
    end

    // Counters: a software write wins over a counted event in the same cycle
    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            evCount_reg[0] <= REG64_RESET;
            evCount_reg[1] <= REG64_RESET;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wrCommit && regSel == SEL_EVCNT && regIdx[1:0] == 2'(c + 1)) begin
                    if (isHigh) begin
                        evCount_reg[c][63:32] <= byteMerge(evCount_reg[c][63:32], dat_i,
                                                           sel_i);
                    end else begin
                        evCount_reg[c][31:0] <= byteMerge(evCount_reg[c][31:0], dat_i,
                                                          sel_i);
                    end
                end else if ((c == 0) ? countEvent0 : countEvent1) begin
                    evCount_reg[c] <= evCount_reg[c] + 64'h0000_0000_0000_0001;
                end
            end
        end
    end

    chunk_mem #(
        .DATA_W(DATA_W),
        .DEPTH(CHUNK_WORDS)
    ) u_chunk (
        .clk(clk),
        .wrEn(wrCommit && regSel == SEL_CHUNK),
        .wrAddr(chunkAddr),
        .wrData(dat_i),
        .wrSel(sel_i),
        .rdAddr(chunkAddr),
        .rdData(chunkRd)
    );

    // Read multiplexer; unmapped words and reserved halves read zero
    always_comb begin
        datNext = WORD_ZERO;
        case (regSel)
            SEL_POWERON: datNext = isHigh ? WORD_ZERO : poweronLow;
            SEL_TEST_CONTROL: begin
                if (!isHigh) begin
                    datNext[TC_STREAM_DIS_BIT] = testCtl_reg[0];
                    datNext[TC_SPLIT_LOCK_DIS_BIT] = testCtl_reg[1];
                end
            end
            SEL_UPDATE_TRIG: datNext = isHigh ? updateTrig_reg[63:32] : updateTrig_reg[31:0];
            SEL_CHUNK: datNext = chunkRd;
            SEL_EVCNT: begin
                if (regIdx[1:0] == 2'h1) begin
                    datNext = isHigh ? evCount_reg[0][63:32] : evCount_reg[0][31:0];
                end else begin
                    datNext = isHigh ? evCount_reg[1][63:32] : evCount_reg[1][31:0];
                end
            end
            default: datNext = WORD_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            dat_o <= WORD_ZERO;
        end else if (state_reg == ST_ACCESS && !we_i) begin
            dat_o <= datNext;
        end
    end
endmodule // poweron_config_and_test_regs

// File: hdl/strap_capture.sv
// Purpose: Synchronise strap pins and hold them from the release of reset onward
// Assumes: Straps are stable around reset release
// Notes: Capture waits for the synchroniser to fill so no reset zero is latched
module strap_capture #(
    parameter int WIDTH = msr_bank_pkg::STRAP_W
) (
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic [WIDTH-1:0] strapPins,
    output logic [WIDTH-1:0] captured,
    output logic captureDone
);
    import msr_bank_pkg::*;

    logic [WIDTH-1:0] syncA_reg;
    logic [WIDTH-1:0] syncB_reg;
    logic [1:0] settle_reg;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= strapPins;
            syncB_reg <= syncA_reg;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            settle_reg <= 2'h0;
            captured <= '0;
            captureDone <= 1'b0;
        end else if (!captureDone) begin
            if (settle_reg == 2'(SYNC_STAGES)) begin
                captured <= syncB_reg;
                captureDone <= 1'b1;
            end else begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end
endmodule // strap_capture

// File: shared/msr_bank_pkg.sv
// Purpose: Shared constants for the power-on configuration and test register bank
// Assumes: 32-bit classic Wishbone register port, one 200 MHz clock
// Notes: Word index times four is the byte address; the high half adds HALF_OFFSET
package msr_bank_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int IDX_W = 8;
    localparam int HALF_BIT = 10;
    localparam logic [ADDR_W-1:0] HALF_OFFSET = 13'h1000;

    // Register indices; byte address of the low word is four times the index
    localparam logic [IDX_W-1:0] IDX_POWERON = 8'h2A;
    localparam logic [IDX_W-1:0] IDX_TEST_CONTROL = 8'h33;
    localparam logic [IDX_W-1:0] IDX_UPDATE_TRIG = 8'h79;
    localparam logic [IDX_W-1:0] IDX_CHUNK0 = 8'h88;
    localparam logic [IDX_W-1:0] IDX_CHUNK1 = 8'h89;
    localparam logic [IDX_W-1:0] IDX_CHUNK2 = 8'h8A;
    localparam logic [IDX_W-1:0] IDX_CHUNK3 = 8'h8B;
    localparam logic [IDX_W-1:0] IDX_EVCNT0 = 8'hC1;
    localparam logic [IDX_W-1:0] IDX_EVCNT1 = 8'hC2;

    // Power-on configuration field positions (low word)
    localparam int POC_BUSINIT_OBS_BIT = 12;
    localparam int POC_QUEUE_DEPTH_BIT = 13;
    localparam int POC_LOW_VECTOR_BIT = 14;
    localparam int POC_REDUNDANCY_BIT = 15;
    localparam int POC_CLUSTER_LSB = 16;
    localparam int POC_CLUSTER_MSB = 17;
    localparam int POC_BUSFREQ_LSB = 18;
    localparam int POC_BUSFREQ_MSB = 19;
    localparam int POC_ARBID_LSB = 20;
    localparam int POC_ARBID_MSB = 21;
    localparam int POC_RATIO_LSB = 22;
    localparam int POC_RATIO_MSB = 25;
    localparam int POC_LOWPOWER_BIT = 26;
    localparam int POC_RATIO_EXT_BIT = 27;
    localparam int POC_STRAP_LSB = 12;
    localparam int STRAP_W = 16;
    localparam logic POC_LOWPOWER_RESET = 1'b0;

    // Bus frequency codes
    localparam logic [1:0] BUSFREQ_66 = 2'h0;
    localparam logic [1:0] BUSFREQ_100 = 2'h2;
    localparam logic [1:0] BUSFREQ_133 = 2'h1;
    localparam logic [1:0] BUSFREQ_RSVD = 2'h3;

    // Test control field positions
    localparam int TC_STREAM_DIS_BIT = 30;
    localparam int TC_SPLIT_LOCK_DIS_BIT = 31;
    localparam logic [1:0] TC_RESET = 2'h0;

    // Reset values and settle counts
    localparam logic [63:0] REG64_RESET = 64'h0000_0000_0000_0000;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;
    localparam int CHUNK_WORDS = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_DONE = 3'b100
    } bus_state_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_POWERON,
        SEL_TEST_CONTROL,
        SEL_UPDATE_TRIG,
        SEL_CHUNK,
        SEL_EVCNT
    } reg_sel_t;
endpackage

// File: verif/poweron_config_and_test_regs_asserts.sv
// Purpose: Port-level checks of the power-on and test control register bank
// Assumes: Straps held still outside reset; accesses start only once configValid is high
// Notes: Register bytes decoded from the package indices for the low word; the high-word check uses literal addresses
module poweron_config_and_test_regs_checker
    import msr_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [msr_bank_pkg::ADDR_W-1:0] adr_i,
    input wire logic [msr_bank_pkg::DATA_W-1:0] dat_i,
    input wire logic [msr_bank_pkg::DATA_W-1:0] dat_o,
    input wire logic we_i,
    input wire logic [msr_bank_pkg::SEL_W-1:0] sel_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    input wire logic ack_o,
    input wire logic strapBusInitObserve,
    input wire logic strapQueueDepthOne,
    input wire logic strapLowVector,
    input wire logic strapRedundancyCheck,
    input wire logic [1:0] strapClusterId,
    input wire logic [1:0] strapBusFreq,
    input wire logic [1:0] strapArbId,
    input wire logic [3:0] strapClockRatio,
    input wire logic strapRatioExt,
    input wire logic lowPowerEnable,
    input wire logic streamBufferDisable,
    input wire logic splitLockDisable,
    input wire logic configValid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic pocAck;
    logic tcAck;
    assign pocAck = ack_o && adr_i == {3'b000, IDX_POWERON, 2'b00};
    assign tcAck = ack_o && adr_i == {3'b000, IDX_TEST_CONTROL, 2'b00};

    strap_read_a: assert property (pocAck && !we_i && configValid |-> dat_o[27:12] ==
        {strapRatioExt, lowPowerEnable, strapClockRatio, strapArbId, strapBusFreq, strapClusterId,
         strapRedundancyCheck, strapLowVector, strapQueueDepthOne, strapBusInitObserve})
        else $error("power-on read differs from straps");
    poc_reserved_a: assert property (pocAck && !we_i |-> dat_o[31:28] == 4'h0)
        else $error("power-on reserved bits not zero");
    hi_word_a: assert property (ack_o && !we_i && adr_i == (HALF_OFFSET | 13'h00A8) |-> dat_o == '0)
        else $error("power-on high word not zero");
    tc_read_a: assert property (tcAck && !we_i |-> dat_o ==
        {splitLockDisable, streamBufferDisable, 30'h0000_0000}) else $error("test control read wrong");
    lp_write_a: assert property (pocAck && we_i && sel_i[3] |-> lowPowerEnable == dat_i[26])
        else $error("low power bit not written");
    lp_hold_a: assert property (!$stable(lowPowerEnable) |-> pocAck && we_i && sel_i[3])
        else $error("low power bit changed without write");
    tc_write_a: assert property (tcAck && we_i && sel_i[3] |->
        {splitLockDisable, streamBufferDisable} == dat_i[31:30]) else $error("test control not written");
    tc_hold_a: assert property (!$stable({splitLockDisable, streamBufferDisable}) |->
        tcAck && we_i && sel_i[3]) else $error("test control changed without write");
    ack_timing_a: assert property ($rose(cyc_i && stb_i) && configValid |->
        !ack_o ##1 !ack_o ##1 ack_o) else $error("ack not two cycles after request");
    ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    cover property (pocAck && we_i && sel_i[3]);
    cover property (tcAck && !we_i && dat_o[31]);
    cover property (ack_o && !we_i && adr_i == (HALF_OFFSET | 13'h022C));
endmodule // poweron_config_and_test_regs_checker

bind poweron_config_and_test_regs poweron_config_and_test_regs_checker
    poweron_config_and_test_regs_checker_inst (.clk(clk), .rst_n(rst_n), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i),
    .ack_o(ack_o), .strapBusInitObserve(strapBusInitObserve), .strapQueueDepthOne(strapQueueDepthOne),
    .strapLowVector(strapLowVector), .strapRedundancyCheck(strapRedundancyCheck),
    .strapClusterId(strapClusterId), .strapBusFreq(strapBusFreq), .strapArbId(strapArbId),
    .strapClockRatio(strapClockRatio), .strapRatioExt(strapRatioExt),
    .lowPowerEnable(lowPowerEnable), .streamBufferDisable(streamBufferDisable),
    .splitLockDisable(splitLockDisable), .configValid(configValid));

// File: verif/poweron_config_and_test_regs_bench.sv
// Purpose: Self-checking bench for the power-on and test control register bank
// Assumes: Classic Wishbone master in the bench, straps changed only under reset
// Notes: Ack is looked at on the falling edge so the rising-edge sample never races the state reg
module poweron_config_and_test_regs_bench;
    import msr_bank_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TIMEOUT_CYCLES = 5000;
    // Strap word lines up with power-on bits 27:12; bit 14 is the writable low power bit
    localparam logic [15:0] STRAPS [4] = '{16'h0000, 16'h2A5A, 16'h15A5, 16'hBFFF};
    localparam logic [31:0] TC_VAL [4] = '{32'hFFFF_FFFF, 32'h4000_0000, 32'h8000_0000, 32'hFFFF_FFFF};
    localparam logic [3:0] TC_SEL [4] = '{4'hF, 4'hF, 4'hF, 4'h7};
    localparam logic [31:0] TC_EXP [4] = '{32'hC000_0000, 32'h4000_0000, 32'h8000_0000, 32'h8000_0000};
    logic clk, rst_n, we, stb, cyc, ack, lowPow, streamDis, splitDis, cfgValid;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] wdat, rdat, rdata;
    logic [SEL_W-1:0] sel;
    logic [15:0] strapVec;
    int nMismatch = 0;
    int checksDone = 0;
    int cycles = 0;

    poweron_config_and_test_regs poweron_config_and_test_regs_inst (.clk(clk), .rst_n(rst_n),
        .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc),
        .ack_o(ack), .strapBusInitObserve(strapVec[0]), .strapQueueDepthOne(strapVec[1]),
        .strapLowVector(strapVec[2]), .strapRedundancyCheck(strapVec[3]),
        .strapClusterId(strapVec[5:4]), .strapBusFreq(strapVec[7:6]), .strapArbId(strapVec[9:8]),
        .strapClockRatio(strapVec[13:10]), .strapRatioExt(strapVec[15]), .countEvent0(1'b0),
        .countEvent1(1'b0), .lowPowerEnable(lowPow), .streamBufferDisable(streamDis),
        .splitLockDisable(splitDis), .updateTriggerPulse(), .configValid(cfgValid));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [ADDR_W-1:0] lo(input logic [IDX_W-1:0] idx);
        return {3'b000, idx, 2'b00};
    endfunction

    function automatic logic [31:0] pocExp(input logic [15:0] pat, input logic lp);
        return {4'h0, pat[15], lp, pat[13:0], 12'h000};
    endfunction

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES) begin
            nMismatch++;
            finishTest();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            nMismatch++;
        end
    endtask

    // Request held until the rising edge that samples ack; a hang falls to the cycle ceiling
    task automatic busCycle(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
                            input logic [3:0] s);
        @(posedge clk);
        adr <= a;
        we <= w;
        wdat <= d;
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(negedge clk);
        while (ack !== 1'b1) @(negedge clk);
        rdata = rdat;
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic readCheck(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                             input logic [31:0] mask);
        busCycle(a, 1'b0, WORD_ZERO, 4'hF);
        check(name, exp & mask, rdata & mask);
    endtask

    task automatic doReset(input logic [15:0] pat);
        rst_n <= 1'b0;
        strapVec <= pat;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        while (cfgValid !== 1'b1) @(posedge clk);
    endtask

    initial begin
        logic [31:0] v;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        wdat = '0;
        sel = '0;
        strapVec = '0;
        // Every bus frequency code, with all zero, two alternating patterns and all ones in the other fields
        for (int i = 0; i < 4; i++) begin
            doReset(STRAPS[i]);
            readCheck("poweron", lo(IDX_POWERON), pocExp(STRAPS[i], 1'b0), 32'hFFFF_F000);
            readCheck("poweron high", HALF_OFFSET | lo(IDX_POWERON), WORD_ZERO, 32'hFFFF_FFFF);
            busCycle(lo(IDX_POWERON), 1'b1, 32'hFFFF_FFFF, 4'h7);
            readCheck("poweron masked", lo(IDX_POWERON), pocExp(STRAPS[i], 1'b0), 32'hFFFF_F000);
            busCycle(lo(IDX_POWERON), 1'b1, 32'hFFFF_FFFF, 4'hF);
            readCheck("poweron set", lo(IDX_POWERON), pocExp(STRAPS[i], 1'b1), 32'hFFFF_F000);
            check("lowPowerEnable", WORD_ZERO | 32'h0000_0001, {WORD_ZERO[31:1], lowPow});
            busCycle(lo(IDX_POWERON), 1'b1, WORD_ZERO, 4'hF);
            check("lowPowerEnable", WORD_ZERO, {WORD_ZERO[31:1], lowPow});
        end
        foreach (TC_VAL[k]) begin
            busCycle(lo(IDX_TEST_CONTROL), 1'b1, TC_VAL[k], TC_SEL[k]);
            readCheck("test control", lo(IDX_TEST_CONTROL), TC_EXP[k], 32'hFFFF_FFFF);
            check("control pins", TC_EXP[k] >> 30, {30'h0000_0000, splitDis, streamDis});
        end
        readCheck("test control high", HALF_OFFSET | lo(IDX_TEST_CONTROL), WORD_ZERO, 32'hFFFF_FFFF);
        // All eight chunk words written before any read, so aliasing would show
        for (int k = 0; k < 8; k++) begin
            busCycle(lo(IDX_CHUNK0 + 8'(k / 2)) | ((k % 2) ? HALF_OFFSET : '0), 1'b1,
                     32'h5A5A_0000 + 32'(k), 4'hF);
        end
        for (int k = 0; k < 8; k++) begin
            readCheck("chunk", lo(IDX_CHUNK0 + 8'(k / 2)) | ((k % 2) ? HALF_OFFSET : '0),
                      32'h5A5A_0000 + 32'(k), 32'hFFFF_FFFF);
        end
        busCycle(lo(IDX_CHUNK3), 1'b1, 32'hFFFF_FFFF, 4'h5);
        v = 32'h5A5A_0006 | 32'h00FF_00FF;
        readCheck("chunk3 bytes", lo(IDX_CHUNK3), v, 32'hFFFF_FFFF);
        busCycle(lo(8'h00), 1'b1, 32'hFFFF_FFFF, 4'hF);
        readCheck("unmapped", lo(8'h00), WORD_ZERO, 32'hFFFF_FFFF);
        finishTest();
    end
endmodule // poweron_config_and_test_regs_bench
